// File: hw/relay_output_condition_selector.sv
// relay output condition selector with AXI4-Lite register access and one interrupt
// assumes all drive inputs are synchronous to aclk and power-up drives aresetn low
// Operation
// - code 0: relay active when drive ready and no fault present.
// - code 2: relay active while motor is powered by the drive.
// - code 3: relay active while reverse direction is commanded.
// - code 5: relay active while ramp regulator stretches accel or decel.
// - code 6: relay active while output frequency exceeds trip level.
// - code 7: relay active while output current exceeds trip level.
// - code 8: relay active while bus voltage exceeds trip level.
// - code 9: relay active while restart attempts exceed the limit.
// - code 10: relay active while analog input exceeds trip level.
// - code 11: network writes trip level; zero turns relay off, nonzero on.
// - code 12: relay active on retries exceeded, restart disabled, or fatal fault.
// - code 13: relay follows bit 6 of the logic command word.
// - trip level is 32 bits, resets to zero, used by codes 6,7,8,10,11.
//
// The register addresses and register access over AXI4-Lite were decided locally.
`timescale 1ns/1ns
module relay_output_condition_selector (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [relay_sel_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [relay_sel_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire relay_sel_pkg::drive_status_t drive_status,
  input wire relay_sel_pkg::drive_meas_t drive_meas,
  input wire logic [7:0] restart_count,
  input wire logic [15:0] logic_cmd_word,
  output logic relay_out,
  output logic irq
);
  import relay_sel_pkg::*;

  function automatic logic above(input logic [15:0] meas, input logic [31:0] lvl);
    above = {16'h0000, meas} > lvl;
  endfunction : above

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[8*i +: 8] = wd[8*i +: 8];
      end
    end
    merge = res;
  endfunction : merge

  // configuration and interrupt state
  logic [4:0] relay_condition_select_r, relay_condition_select_nxt;
  logic [31:0] relay_trip_level_r, relay_trip_level_nxt;
  logic [7:0] restart_attempt_limit_r, restart_attempt_limit_nxt;
  logic [1:0] irq_stat_r, irq_stat_nxt;
  logic [1:0] irq_en_r, irq_en_nxt;
  logic irq_r, irq_nxt;
  logic relay_r, relay_nxt;

  // bus state
  logic aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt;
  logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;

  logic do_wr;
  logic retries_exceeded;
  logic [1:0] irq_clr;

  assign do_wr = aw_full_r & w_full_r & ~bvalid_r;
  assign retries_exceeded = restart_count > restart_attempt_limit_r;

  // condition selection
  always_comb begin
    relay_nxt = 1'b0;
    case (relay_code_t'(relay_condition_select_r))
      CODE_READY_FAULT: relay_nxt = drive_status.ready & ~drive_status.fault;
      CODE_AT_FREQ: relay_nxt = drive_status.at_freq;
      CODE_MOTOR_RUNNING: relay_nxt = drive_status.running;
      CODE_REVERSE: relay_nxt = drive_status.reverse;
      CODE_MOTOR_OVERLOAD: relay_nxt = drive_status.overload;
      CODE_RAMP_REG: relay_nxt = drive_status.ramp_reg;
      CODE_ABOVE_FREQ: relay_nxt = above(drive_meas.freq_dhz, relay_trip_level_r);
      CODE_ABOVE_CUR: relay_nxt = above(drive_meas.cur_dpct, relay_trip_level_r);
      bus_voltage_over_code: relay_nxt = above(drive_meas.bus_dvolt, relay_trip_level_r);
      CODE_RETRIES_EXCEEDED: relay_nxt = retries_exceeded;
      CODE_ABOVE_ANALOG: relay_nxt = above(drive_meas.ain_dpct, relay_trip_level_r);
      network_driven_code: relay_nxt = |relay_trip_level_r;
      unrecoverable_fault_code: begin
        relay_nxt = retries_exceeded | (restart_attempt_limit_r == 8'h00) | drive_status.nonres_fault;
      end
      CODE_CMD_BIT: relay_nxt = logic_cmd_word[CMD_RELAY_BIT];
      default: relay_nxt = 1'b0;
    endcase
  end

  // register writes and interrupt status
  always_comb begin
    relay_condition_select_nxt = relay_condition_select_r;
    relay_trip_level_nxt = relay_trip_level_r;
    restart_attempt_limit_nxt = restart_attempt_limit_r;
    irq_en_nxt = irq_en_r;
    irq_clr = 2'b00;
    bresp_nxt = bresp_r;
    if (do_wr) begin
      bresp_nxt = RESP_OKAY;
      case (aw_addr_r)
        SEL_OFF: begin
          if (w_strb_r[0]) begin
            relay_condition_select_nxt = w_data_r[4:0];
          end
        end
        LEVEL_OFF: relay_trip_level_nxt = merge(relay_trip_level_r, w_data_r, w_strb_r);
        LIMIT_OFF: begin
          if (w_strb_r[0]) begin
            restart_attempt_limit_nxt = w_data_r[7:0];
          end
        end
        IRQ_CLR_OFF: begin
          if (w_strb_r[0]) begin
            irq_clr = w_data_r[1:0];
          end
        end
        IRQ_EN_OFF: begin
          if (w_strb_r[0]) begin
            irq_en_nxt = w_data_r[1:0];
          end
        end
        STATE_OFF, IRQ_STAT_OFF: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_DECERR;
      endcase
    end
    // an edge in the clearing cycle stays set
    irq_stat_nxt = irq_stat_r & ~irq_clr;
    irq_stat_nxt[IRQ_RISE_BIT] = irq_stat_nxt[IRQ_RISE_BIT] | (relay_nxt & ~relay_r);
    irq_stat_nxt[IRQ_FALL_BIT] = irq_stat_nxt[IRQ_FALL_BIT] | (~relay_nxt & relay_r);
    irq_nxt = |(irq_stat_r & irq_en_r);
  end

  // bus handshakes; write channels taken in either order, one transfer at a time
  always_comb begin
    aw_full_nxt = (aw_full_r | (s_axi_awvalid & awready_r)) & ~do_wr;
    w_full_nxt = (w_full_r | (s_axi_wvalid & wready_r)) & ~do_wr;
    aw_addr_nxt = (s_axi_awvalid & awready_r) ? s_axi_awaddr : aw_addr_r;
    w_data_nxt = (s_axi_wvalid & wready_r) ? s_axi_wdata : w_data_r;
    w_strb_nxt = (s_axi_wvalid & wready_r) ? s_axi_wstrb : w_strb_r;
    bvalid_nxt = do_wr | (bvalid_r & ~s_axi_bready);
    awready_nxt = ~aw_full_nxt & ~bvalid_nxt;
    wready_nxt = ~w_full_nxt & ~bvalid_nxt;
    rvalid_nxt = (s_axi_arvalid & arready_r) | (rvalid_r & ~s_axi_rready);
    arready_nxt = ~rvalid_nxt;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (s_axi_arvalid & arready_r) begin
      rdata_nxt = 32'h0000_0000;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
        SEL_OFF: rdata_nxt[4:0] = relay_condition_select_r;
        LEVEL_OFF: rdata_nxt = relay_trip_level_r;
        LIMIT_OFF: rdata_nxt[7:0] = restart_attempt_limit_r;
        STATE_OFF: begin
          rdata_nxt[STATE_RELAY_BIT] = relay_r;
          rdata_nxt[STATE_COND_LSB +: 8] = drive_status;
        end
        IRQ_STAT_OFF: rdata_nxt[1:0] = irq_stat_r;
        IRQ_EN_OFF: rdata_nxt[1:0] = irq_en_r;
        IRQ_CLR_OFF: rdata_nxt = 32'h0000_0000;
        default: rresp_nxt = RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      relay_condition_select_r <= SEL_RST;
      relay_trip_level_r <= LEVEL_RST;
      restart_attempt_limit_r <= LIMIT_RST;
      irq_stat_r <= 2'h0;
      irq_en_r <= IRQ_EN_RST;
      irq_r <= 1'b0;
      relay_r <= 1'b0;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= RESP_OKAY;
    end else begin
      relay_condition_select_r <= relay_condition_select_nxt;
      relay_trip_level_r <= relay_trip_level_nxt;
      restart_attempt_limit_r <= restart_attempt_limit_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_en_r <= irq_en_nxt;
      irq_r <= irq_nxt;
      relay_r <= relay_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign relay_out = relay_r;
  assign irq = irq_r;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_ready_relay: assert property ((relay_condition_select_r == 5'h00)
    |=> relay_r == ($past(drive_status.ready) & ~$past(drive_status.fault)))
    else $error("ready code relay mismatch");
  a_running_relay: assert property ((relay_condition_select_r == 5'h02) ##1 $stable(relay_condition_select_r)
    |-> relay_r == $past(drive_status.running))
    else $error("running code relay mismatch");
  a_reverse_relay: assert property ((relay_condition_select_r == 5'h03)
    |=> relay_r == $past(drive_status.reverse))
    else $error("reverse code relay mismatch");
  a_ramp_relay: assert property ((relay_condition_select_r == 5'h05) && drive_status.ramp_reg
    |=> relay_r)
    else $error("ramp code relay not set");
  a_freq_relay: assert property ((relay_condition_select_r == 5'h06)
    |=> relay_r == ({16'h0000, $past(drive_meas.freq_dhz)} > $past(relay_trip_level_r)))
    else $error("frequency compare mismatch");
  a_cur_relay: assert property ((relay_condition_select_r == 5'h07)
    && ({16'h0000, drive_meas.cur_dpct} == relay_trip_level_r) |=> !relay_r)
    else $error("current compare not strict");
  a_volt_relay: assert property ((relay_condition_select_r == 5'h08)
    |=> relay_r == ({16'h0000, $past(drive_meas.bus_dvolt)} > $past(relay_trip_level_r)))
    else $error("bus voltage compare mismatch");
  a_retry_relay: assert property ((relay_condition_select_r == 5'h09)
    |=> relay_r == ($past(restart_count) > $past(restart_attempt_limit_r)))
    else $error("retry code relay mismatch");
  a_analog_relay: assert property ((relay_condition_select_r == 5'h0a)
    |=> relay_r == ({16'h0000, $past(drive_meas.ain_dpct)} > $past(relay_trip_level_r)))
    else $error("analog compare mismatch");
  a_network_relay: assert property ((relay_condition_select_r == 5'h0b) && (relay_trip_level_r == 32'h0)
    |=> !relay_r)
    else $error("network code relay on at zero");
  a_fatal_relay: assert property ((relay_condition_select_r == 5'h0c) && drive_status.nonres_fault
    |=> relay_r)
    else $error("fatal fault relay not set");
  a_cmd_relay: assert property ((relay_condition_select_r == 5'h0d)
    |=> relay_r == $past(logic_cmd_word[6]))
    else $error("command bit relay mismatch");
  a_level_write: assert property (do_wr && (aw_addr_r == LEVEL_OFF) && (w_strb_r == 4'hf)
    |=> relay_trip_level_r == $past(w_data_r))
    else $error("trip level write lost");
  a_reserved_off: assert property ((relay_condition_select_r > 5'h0d) [*2] |-> !relay_r)
    else $error("relay on with reserved code");
  a_irq_level: assert property (irq_r == $past(|(irq_stat_r & irq_en_r)))
    else $error("interrupt output mismatch");

endmodule : relay_output_condition_selector

// File: hw/relay_sel_pkg.sv
// relay condition selector: register map, field layout, reset values, carriers
// assumes a 32-bit AXI4-Lite slave with byte addresses on word boundaries
package relay_sel_pkg;

  localparam int ADDR_W = 8;
  localparam logic [7:0] SEL_OFF = 8'h00;
  localparam logic [7:0] LEVEL_OFF = 8'h04;
  localparam logic [7:0] LIMIT_OFF = 8'h08;
  localparam logic [7:0] STATE_OFF = 8'h0c;
  localparam logic [7:0] IRQ_STAT_OFF = 8'h10;
  localparam logic [7:0] IRQ_CLR_OFF = 8'h14;
  localparam logic [7:0] IRQ_EN_OFF = 8'h18;

  localparam logic [4:0] SEL_RST = 5'h00;
  localparam logic [31:0] LEVEL_RST = 32'h0000_0000;
  localparam logic [7:0] LIMIT_RST = 8'h00;
  localparam logic [1:0] IRQ_EN_RST = 2'h0;

  localparam int IRQ_RISE_BIT = 0;
  localparam int IRQ_FALL_BIT = 1;
  localparam int STATE_RELAY_BIT = 0;
  localparam int STATE_COND_LSB = 8;
  localparam int CMD_RELAY_BIT = 6;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_DECERR = 2'b11;

  typedef enum logic [4:0] {
    CODE_READY_FAULT = 5'b00000,
    CODE_AT_FREQ = 5'b00001,
    CODE_MOTOR_RUNNING = 5'b00010,
    CODE_REVERSE = 5'b00011,
    CODE_MOTOR_OVERLOAD = 5'b00100,
    CODE_RAMP_REG = 5'b00101,
    CODE_ABOVE_FREQ = 5'b00110,
    CODE_ABOVE_CUR = 5'b00111,
    bus_voltage_over_code = 5'b01000,
    CODE_RETRIES_EXCEEDED = 5'b01001,
    CODE_ABOVE_ANALOG = 5'b01010,
    network_driven_code = 5'b01011,
    unrecoverable_fault_code = 5'b01100,
    CODE_CMD_BIT = 5'b01101
  } relay_code_t;

  typedef struct packed {
    logic ready;
    logic fault;
    logic running;
    logic reverse;
    logic ramp_reg;
    logic at_freq;
    logic overload;
    logic nonres_fault;
  } drive_status_t;

  // all quantities in tenths of the displayed unit, same scale as the trip level
  typedef struct packed {
    logic [15:0] freq_dhz;
    logic [15:0] cur_dpct;
    logic [15:0] bus_dvolt;
    logic [15:0] ain_dpct;
  } drive_meas_t;

endpackage : relay_sel_pkg

// File: tb/relay_contacts_model.sv
// relay contacts seen by the external equipment
// assumes coil driven by the selector's relay output, same clock
`timescale 1ns/1ns
module relay_contacts_model (
  input wire logic aclk,
  input wire logic coil,
  output logic contact_closed
);
  // contacts settle one clock after the coil, never faster
  always_ff @(posedge aclk) begin
    contact_closed <= coil;
  end
endmodule : relay_contacts_model

// File: tb/relay_output_condition_selector_tb.sv
// self-checking bench for the relay condition selector
// assumes the design's AXI4-Lite timing and register map, one write or read at a time
`timescale 1ns/1ns
module relay_output_condition_selector_tb;
  import relay_sel_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, relay_out, irq, contact_closed;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  drive_status_t st = '0;
  drive_meas_t meas = '0;
  logic [7:0] rc = 8'h00;
  logic [15:0] cmd = 16'h0000;
  int error_cnt = 0;
  int comparisons = 0;
  logic [31:0] lv_code [4] = '{32'h6, 32'h7, 32'h8, 32'ha};
  logic [31:0] lv_top [4] = '{32'h0fa0, 32'h0708, 32'h1fd6, 32'h03e8};
  logic [31:0] sc [5] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h5};
  logic [7:0] sm [5] = '{8'h04, 8'h20, 8'h10, 8'h02, 8'h08};

  always #50 aclk = ~aclk;

  relay_output_condition_selector u_relay_output_condition_selector (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .drive_status(st), .drive_meas(meas), .restart_count(rc), .logic_cmd_word(cmd),
    .relay_out(relay_out), .irq(irq)
  );

  relay_contacts_model u_relay_contacts_model (.aclk(aclk), .coil(relay_out), .contact_closed(contact_closed));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready === 1'b1) awvalid <= 1'b0;
      if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask : rd

  // relay settles one edge after the inputs, contacts one more
  task automatic rel(input logic e);
    repeat (3) @(posedge aclk);
    chk({31'h0, relay_out}, {31'h0, e});
    chk({31'h0, contact_closed}, {31'h0, e});
  endtask : rel

  task automatic end_sim();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : end_sim

  initial begin
    #(100 * 20000);
    error_cnt++;
    end_sim();
  end

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rel(1'b0);
    rd(SEL_OFF, 32'h0, RESP_OKAY);
    rd(LEVEL_OFF, 32'h0, RESP_OKAY);
    rd(LIMIT_OFF, 32'h0, RESP_OKAY);
    rd(IRQ_EN_OFF, 32'h0, RESP_OKAY);
    rd(8'h20, 32'h0, RESP_DECERR);
    wr(8'h20, 32'hffff_ffff, RESP_DECERR);
    wr(STATE_OFF, 32'hffff_ffff, RESP_OKAY);
    wr(LEVEL_OFF, 32'hdead_beef, RESP_OKAY);
    rd(LEVEL_OFF, 32'hdead_beef, RESP_OKAY);
    st <= drive_status_t'(8'h80);
    rel(1'b1);
    rd(STATE_OFF, 32'h0000_8001, RESP_OKAY);
    st <= drive_status_t'(8'hc0);
    rel(1'b0);
    for (int i = 0; i < 5; i++) begin
      wr(SEL_OFF, sc[i], RESP_OKAY);
      st <= drive_status_t'(~sm[i]);
      rel(1'b0);
      st <= drive_status_t'(sm[i]);
      rel(1'b1);
    end
    st <= '0;
    for (int i = 0; i < 4; i++) begin
      wr(SEL_OFF, lv_code[i], RESP_OKAY);
      wr(LEVEL_OFF, lv_top[i], RESP_OKAY);
      meas <= drive_meas_t'(64'(lv_top[i]) << (48 - 16 * i));
      rel(1'b0);
      meas <= drive_meas_t'(64'(lv_top[i] + 32'h1) << (48 - 16 * i));
      rel(1'b1);
    end
    meas <= '0;
    wr(IRQ_CLR_OFF, 32'h3, RESP_OKAY);
    wr(IRQ_EN_OFF, 32'h1, RESP_OKAY);
    wr(SEL_OFF, 32'hb, RESP_OKAY);
    wr(LEVEL_OFF, 32'h1, RESP_OKAY);
    rel(1'b1);
    chk({31'h0, irq}, 32'h1);
    rd(IRQ_STAT_OFF, 32'h1, RESP_OKAY);
    wr(IRQ_CLR_OFF, 32'h1, RESP_OKAY);
    wr(LEVEL_OFF, 32'h0, RESP_OKAY);
    rel(1'b0);
    chk({31'h0, irq}, 32'h0);
    rd(IRQ_STAT_OFF, 32'h2, RESP_OKAY);
    // fall event only shows on irq once its enable bit is set
    wr(IRQ_EN_OFF, 32'h2, RESP_OKAY);
    @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    wr(IRQ_CLR_OFF, 32'h3, RESP_OKAY);
    rd(IRQ_STAT_OFF, 32'h0, RESP_OKAY);
    chk({31'h0, irq}, 32'h0);
    wr(SEL_OFF, 32'h9, RESP_OKAY);
    wr(LIMIT_OFF, 32'h3, RESP_OKAY);
    rc <= 8'h03;
    rel(1'b0);
    rc <= 8'h04;
    rel(1'b1);
    wr(SEL_OFF, 32'hc, RESP_OKAY);
    rc <= 8'h00;
    rel(1'b0);
    st <= drive_status_t'(8'h01);
    rel(1'b1);
    st <= '0;
    wr(LIMIT_OFF, 32'h0, RESP_OKAY);
    rel(1'b1);
    wr(LIMIT_OFF, 32'h3, RESP_OKAY);
    rc <= 8'h04;
    rel(1'b1);
    rc <= 8'h00;
    wr(SEL_OFF, 32'hd, RESP_OKAY);
    cmd <= 16'hffbf;
    rel(1'b0);
    cmd <= 16'h0040;
    rel(1'b1);
    // mid-run reset stands for a power loss: relay back to shelf, settings to defaults
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rel(1'b0);
    chk({31'h0, irq}, 32'h0);
    rd(SEL_OFF, 32'h0, RESP_OKAY);
    rd(LEVEL_OFF, 32'h0, RESP_OKAY);
    rd(IRQ_EN_OFF, 32'h0, RESP_OKAY);
    rd(IRQ_STAT_OFF, 32'h0, RESP_OKAY);
    st <= drive_status_t'(8'hbf);
    meas <= '1;
    rc <= 8'hff;
    cmd <= 16'hffff;
    wr(LEVEL_OFF, 32'h1, RESP_OKAY);
    wr(SEL_OFF, 32'he, RESP_OKAY);
    rel(1'b0);
    wr(SEL_OFF, 32'h1f, RESP_OKAY);
    rel(1'b0);
    end_sim();
  end
endmodule : relay_output_condition_selector_tb
